// [hdl/zxd_pkg.sv]
// Constants and types shared by the zero-cross detector control block.
// Assumes a 40 MHz peripheral clock and an APB slave with 32-bit data.
package zxd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indices, byte address is four times the index
   localparam logic [5:0] ZXD_IDX_CONTROL = 6'h00;
   localparam logic [5:0] ZXD_IDX_IRQ_CONFIG = 6'h02;
   localparam logic [5:0] ZXD_IDX_STATUS = 6'h03;
   localparam logic [5:0] ZXD_IDX_IRQ_STATUS = 6'h04;
   localparam logic [5:0] ZXD_IDX_IRQ_ENABLE = 6'h05;
   localparam logic [5:0] ZXD_IDX_IRQ_CLEAR = 6'h06;
   localparam logic [5:0] ZXD_IDX_CROSS_COUNT = 6'h07;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ZXD_CTRL_ENABLE_BIT = 0;
   localparam int ZXD_CTRL_INVERT_BIT = 3;
   localparam int ZXD_CTRL_OUTPUT_PIN_ENABLE_BIT = 6;
   localparam int ZXD_CTRL_STANDBY_BIT = 7;
   localparam int ZXD_MODE_LSB = 0;
   localparam int ZXD_STAT_FLAG_BIT = 0;
   localparam int ZXD_STAT_STATE_BIT = 4;
   localparam int ZXD_IRQ_CROSS_BIT = 0;
   localparam int ZXD_IRQ_TOGGLE_BIT = 1;
   localparam int ZXD_IRQ_WRAP_BIT = 2;
   localparam int ZXD_IRQ_W = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and writable masks
   localparam logic [7:0] ZXD_CONTROL_RST = 8'h00;
   localparam logic [7:0] ZXD_CONTROL_MASK = 8'hC9;
   localparam logic [1:0] ZXD_MODE_RST = 2'h0;
   localparam logic [2:0] ZXD_IRQ_ENABLE_RST = 3'h1;
   localparam logic [15:0] ZXD_COUNT_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Edge select codes
   typedef logic [1:0] zxd_mode_t;
   localparam zxd_mode_t ZXD_MODE_NONE = 2'h0;
   localparam zxd_mode_t ZXD_MODE_RISING = 2'h1;
   localparam zxd_mode_t ZXD_MODE_FALLING = 2'h2;
   localparam zxd_mode_t ZXD_MODE_BOTH = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Sleep mode codes from the power manager
   typedef logic [1:0] zxd_sleep_t;
   localparam zxd_sleep_t ZXD_SLEEP_ACTIVE = 2'h0;
   localparam zxd_sleep_t ZXD_SLEEP_IDLE = 2'h1;
   localparam zxd_sleep_t ZXD_SLEEP_STANDBY = 2'h2;
   localparam zxd_sleep_t ZXD_SLEEP_POWERDOWN = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int ZXD_SYNC_STAGES = 3;

endpackage : zxd_pkg

// [hdl/zxd_sync.sv]
// Multi-stage level synchroniser for the comparator output.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module zxd_sync #(
   parameter int STAGES = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic level_i,
   output logic level_o
);

   logic [STAGES-1:0] chain_q;

   // Shift chain, only the last stage is read
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         chain_q <= '0;
      end else if (ce_i) begin
         chain_q <= {chain_q[STAGES-2:0], level_i};
      end
   end

   assign level_o = chain_q[STAGES-1];

endmodule : zxd_sync

// [hdl/zxd_edge.sv]
// Edge finder on the synchronised detector level with edge selection.
// Assumes level_i is already synchronous to clk_i.
`timescale 1ns/1ps
module zxd_edge
   import zxd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic active_i,
   input wire logic level_i,
   input wire zxd_mode_t mode_i,
   output logic hit_o,
   output logic toggle_o
);

   logic prev_q;
   logic rise;
   logic fall;

   // Last sampled level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
      end else if (ce_i && active_i) begin
         prev_q <= level_i;
      end
   end

   assign rise = active_i && level_i && !prev_q;
   assign fall = active_i && !level_i && prev_q;
   assign toggle_o = rise || fall;

   // Edge selection
   always_comb begin
      case (mode_i)
         ZXD_MODE_RISING: hit_o = rise;
         ZXD_MODE_FALLING: hit_o = fall;
         ZXD_MODE_BOTH: hit_o = rise || fall;
         default: hit_o = 1'b0;
      endcase
   end

endmodule : zxd_edge

// [hdl/zxd_top.sv]
// Control and status logic of the zero-cross detector, APB register slave.
// Assumes comparator output comp_i is asynchronous; APB and sleep inputs are on clk_i.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module zxd_top
   import zxd_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int COUNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire zxd_sleep_t sleep_mode_i,
   input wire logic comp_i,
   output logic detector_enable_o,
   output logic pin_o,
   output logic pin_oe_n_o,
   output logic event_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] control_q;
   zxd_mode_t mode_q;
   logic [ZXD_IRQ_W-1:0] irq_enable_q;
   logic cross_flag_q;
   logic toggle_flag_q;
   logic wrap_flag_q;
   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;
   logic [31:0] rdata_q;
   logic err_q;
   logic setup;
   logic access;
   logic wr_en;
   logic [5:0] index;
   logic aligned;
   logic mapped;
   logic read_only;
   logic active;
   logic out_level;
   logic sync_level;
   logic state;
   logic hit;
   logic toggle;
   logic wrap;
   logic clr_cross;
   logic clr_toggle;
   logic clr_wrap;
   logic clr_count;
   logic [31:0] rdata_d;
   logic [ZXD_IRQ_W-1:0] irq_status;

   ////////////////////////////////////////////////////////////////////////////////
   // Power gating of the detector
   always_comb begin
      case (sleep_mode_i)
         ZXD_SLEEP_ACTIVE: active = control_q[ZXD_CTRL_ENABLE_BIT];
         ZXD_SLEEP_IDLE: active = control_q[ZXD_CTRL_ENABLE_BIT];
         ZXD_SLEEP_STANDBY: active = control_q[ZXD_CTRL_ENABLE_BIT]
                                     && control_q[ZXD_CTRL_STANDBY_BIT];
         ZXD_SLEEP_POWERDOWN: active = 1'b0;
         default: active = 1'b0;
      endcase
   end

   assign detector_enable_o = active;

   ////////////////////////////////////////////////////////////////////////////////
   // Asynchronous output paths
   assign out_level = active && (comp_i ^ control_q[ZXD_CTRL_INVERT_BIT]);
   assign event_o = out_level;
   assign pin_o = out_level && control_q[ZXD_CTRL_OUTPUT_PIN_ENABLE_BIT];
   assign pin_oe_n_o = !(active && control_q[ZXD_CTRL_OUTPUT_PIN_ENABLE_BIT]);

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronised state and edges
   zxd_sync #(
      .STAGES(ZXD_SYNC_STAGES)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .level_i(comp_i),
      .level_o(sync_level)
   );

   assign state = active && (sync_level ^ control_q[ZXD_CTRL_INVERT_BIT]);

   zxd_edge u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .active_i(active),
      .level_i(state),
      .mode_i(mode_q),
      .hit_o(hit),
      .toggle_o(toggle)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode
   assign setup = psel_i && !penable_i;
   assign access = psel_i && penable_i;
   assign pready_o = access;
   assign index = paddr_i[7:2];
   assign aligned = (paddr_i[1:0] == 2'h0) && ((paddr_i >> 8) == '0);

   always_comb begin
      case (index)
         ZXD_IDX_CONTROL: mapped = 1'b1;
         ZXD_IDX_IRQ_CONFIG: mapped = 1'b1;
         ZXD_IDX_STATUS: mapped = 1'b1;
         ZXD_IDX_IRQ_STATUS: mapped = 1'b1;
         ZXD_IDX_IRQ_ENABLE: mapped = 1'b1;
         ZXD_IDX_IRQ_CLEAR: mapped = 1'b1;
         ZXD_IDX_CROSS_COUNT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign read_only = (index == ZXD_IDX_IRQ_STATUS);
   assign wr_en = ce_i && access && pwrite_i && pstrb_i[0] && aligned && mapped
                  && !read_only && !err_q;

   // Error answer held from setup to access
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_q <= 1'b0;
      end else if (ce_i && setup) begin
         err_q <= !(aligned && mapped) || (pwrite_i && read_only);
      end
   end

   assign pslverr_o = access && err_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         control_q <= ZXD_CONTROL_RST;
      end else if (wr_en && index == ZXD_IDX_CONTROL) begin
         control_q <= pwdata_i[7:0] & ZXD_CONTROL_MASK;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= ZXD_MODE_RST;
      end else if (wr_en && index == ZXD_IDX_IRQ_CONFIG) begin
         mode_q <= pwdata_i[ZXD_MODE_LSB +: 2];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_enable_q <= ZXD_IRQ_ENABLE_RST;
      end else if (wr_en && index == ZXD_IDX_IRQ_ENABLE) begin
         irq_enable_q <= pwdata_i[ZXD_IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky flags, a set in the clearing cycle wins
   assign clr_cross = wr_en && ((index == ZXD_IDX_STATUS && pwdata_i[ZXD_STAT_FLAG_BIT])
                     || (index == ZXD_IDX_IRQ_CLEAR && pwdata_i[ZXD_IRQ_CROSS_BIT]));
   assign clr_toggle = wr_en && index == ZXD_IDX_IRQ_CLEAR && pwdata_i[ZXD_IRQ_TOGGLE_BIT];
   assign clr_wrap = wr_en && index == ZXD_IDX_IRQ_CLEAR && pwdata_i[ZXD_IRQ_WRAP_BIT];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cross_flag_q <= 1'b0;
      end else if (ce_i) begin
         cross_flag_q <= (cross_flag_q && !clr_cross) || hit;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         toggle_flag_q <= 1'b0;
      end else if (ce_i) begin
         toggle_flag_q <= (toggle_flag_q && !clr_toggle) || toggle;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wrap_flag_q <= 1'b0;
      end else if (ce_i) begin
         wrap_flag_q <= (wrap_flag_q && !clr_wrap) || wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Crossing counter, a write clears it
   assign clr_count = wr_en && index == ZXD_IDX_CROSS_COUNT;
   assign wrap = hit && (count_q == {COUNT_W{1'b1}});

   always_comb begin
      count_d = count_q;
      if (clr_count) begin
         count_d = '0;
      end
      if (hit) begin
         count_d = count_d + COUNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= ZXD_COUNT_RST[COUNT_W-1:0];
      end else if (ce_i) begin
         count_q <= count_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt
   assign irq_status[ZXD_IRQ_CROSS_BIT] = cross_flag_q;
   assign irq_status[ZXD_IRQ_TOGGLE_BIT] = toggle_flag_q;
   assign irq_status[ZXD_IRQ_WRAP_BIT] = wrap_flag_q;

   assign irq_o = (cross_flag_q && (mode_q != ZXD_MODE_NONE)
                   && irq_enable_q[ZXD_IRQ_CROSS_BIT])
                  || (toggle_flag_q && irq_enable_q[ZXD_IRQ_TOGGLE_BIT])
                  || (wrap_flag_q && irq_enable_q[ZXD_IRQ_WRAP_BIT]);

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup cycle
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (index)
         ZXD_IDX_CONTROL: rdata_d[7:0] = control_q;
         ZXD_IDX_IRQ_CONFIG: rdata_d[ZXD_MODE_LSB +: 2] = mode_q;
         ZXD_IDX_STATUS: begin
            rdata_d[ZXD_STAT_FLAG_BIT] = cross_flag_q;
            rdata_d[ZXD_STAT_STATE_BIT] = state;
         end
         ZXD_IDX_IRQ_STATUS: rdata_d[ZXD_IRQ_W-1:0] = irq_status;
         ZXD_IDX_IRQ_ENABLE: rdata_d[ZXD_IRQ_W-1:0] = irq_enable_q;
         ZXD_IDX_CROSS_COUNT: rdata_d[COUNT_W-1:0] = count_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce_i && setup) begin
         rdata_q <= (aligned && !pwrite_i) ? rdata_d : 32'h0000_0000;
      end
   end

   assign prdata_o = rdata_q;

endmodule : zxd_top

// [verification/zxd_monitor.sv]
// Checker on the ports of the zero-cross detector block.
// Assumes it is bound to zxd_top and that ce_i is held high.
`timescale 1ns/1ps
module zxd_monitor
   import zxd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire zxd_sleep_t sleep_mode_i,
   input wire logic comp_i,
   input wire logic detector_enable_o,
   input wire logic pin_o,
   input wire logic pin_oe_n_o,
   input wire logic event_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic wr;
   logic comp_q;
   zxd_sleep_t sleep_q;
   logic [3:0] quiet_q;
   assign wr = psel_i & penable_i & pwrite_i;
   ////////////////////////////////////////////////////////////
   // Cycles since the last possible cause of an edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         comp_q <= 1'b0;
         sleep_q <= ZXD_SLEEP_ACTIVE;
         quiet_q <= 4'h0;
      end else begin
         comp_q <= comp_i;
         sleep_q <= sleep_mode_i;
         if (comp_i != comp_q || wr || sleep_mode_i != sleep_q) quiet_q <= 4'h0;
         else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   pin_follow_a: assert property (!pin_oe_n_o |-> pin_o == event_o)
      else $error("pin differs from event");
   pin_off_a: assert property (!detector_enable_o |-> pin_oe_n_o && !pin_o)
      else $error("pin driven while off");
   event_off_a: assert property (!detector_enable_o |-> !event_o)
      else $error("event high while off");
   pdown_off_a: assert property (
      sleep_mode_i == ZXD_SLEEP_POWERDOWN |-> !detector_enable_o)
      else $error("detector on in power-down");
   idle_keep_a: assert property ((sleep_mode_i == ZXD_SLEEP_IDLE &&
      $past(sleep_mode_i) == ZXD_SLEEP_ACTIVE && !$past(wr)) |-> $stable(detector_enable_o))
      else $error("idle changed detector");
   event_track_a: assert property ((detector_enable_o && $stable(detector_enable_o) &&
      $changed(comp_i) && !$past(wr)) |-> $changed(event_o))
      else $error("event ignores comparator");
   irq_hold_a: assert property ($fell(irq_o) |-> $past(wr))
      else $error("irq fell without a write");
   irq_cause_a: assert property ($rose(irq_o) |-> quiet_q <= 4'h6)
      else $error("irq rose without a cause");
   irq_rise_c: cover property ($rose(irq_o));
   pin_on_c: cover property (!pin_oe_n_o && pin_o);
   pdown_c: cover property (sleep_mode_i == ZXD_SLEEP_POWERDOWN);
endmodule : zxd_monitor

// [verification/zxd_comp_model.sv]
// Model of the analog comparator output feeding the detector.
// Assumes the bench sets a target level and a lag in clock cycles.
`timescale 1ns/1ps
module zxd_comp_model (
   input wire logic clk_i,
   input wire logic level_i,
   input wire logic [3:0] lag_i,
   output logic comp_o
);
   logic [3:0] wait_q;
   initial comp_o = 1'b0;
   initial wait_q = 4'h0;
   // Output follows the target after the lag
   always @(posedge clk_i) begin
      if (comp_o == level_i) wait_q <= 4'h0;
      else if (wait_q >= lag_i) comp_o <= level_i;
      else wait_q <= wait_q + 4'h1;
   end
endmodule : zxd_comp_model

// [verification/tb_zero_cross_detect_ctrl.sv]
// Testbench of the zero-cross detector block over APB.
// Assumes a 40 MHz clock and a comparator model on comp_i.
`timescale 1ns/1ps
module tb_zero_cross_detect_ctrl
   import zxd_pkg::*;
();
   logic clk = 1'b0;
   logic rst, psel, penable, pwrite, level, comp, pready, pslverr, den, pin, oe_n, evt, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] lag;
   zxd_sleep_t sleep;
   int miscompares = 0;
   int tests_run = 0;
   always #12.5 clk = ~clk;
   zxd_top #(.ADDR_W(8), .COUNT_W(16)) DUT (.clk_i(clk), .rst_i(rst), .ce_i(1'b1),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sleep_mode_i(sleep), .comp_i(comp), .detector_enable_o(den),
      .pin_o(pin), .pin_oe_n_o(oe_n), .event_o(evt), .irq_o(irq));
   zxd_comp_model CMP (.clk_i(clk), .level_i(level), .lag_i(lag), .comp_o(comp));
   ////////////////////////////////////////////////////////////
   task automatic final_report();
      if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk1(input string what, input logic exp, input logic got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask : chk1
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, {idx, 2'b00}, {24'h0, d}, r, e);
   endtask : wreg
   task automatic rreg(input string what, input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, {idx, 2'b00}, 32'h0, r, e);
      chk(what, exp, r);
   endtask : rreg
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      final_report();
   end
   initial begin
      logic [31:0] r;
      logic e;
      logic f;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      level = 1'b0;
      lag = 4'h0;
      sleep = ZXD_SLEEP_ACTIVE;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rreg("control", ZXD_IDX_CONTROL, 32'h0);
      rreg("irq config", ZXD_IDX_IRQ_CONFIG, 32'h0);
      rreg("status", ZXD_IDX_STATUS, 32'h0);
      rreg("irq enable", ZXD_IDX_IRQ_ENABLE, 32'h1);
      apb(1'b0, 8'h24, 32'h0, r, e);
      chk1("unmapped error", 1'b1, e);
      chk1("detector off", 1'b0, den);
      wreg(ZXD_IDX_CONTROL, 8'h01);
      chk1("detector on", 1'b1, den);
      for (int m = 0; m < 4; m++) begin
         wreg(ZXD_IDX_IRQ_CONFIG, 8'(m));
         wreg(ZXD_IDX_STATUS, 8'h01);
         level <= 1'b1;
         lag <= 4'(m);
         repeat (12) @(posedge clk);
         f = (m == 1 || m == 3);
         rreg("rise status", ZXD_IDX_STATUS, {27'h0, 1'b1, 3'h0, f});
         chk1("rise irq", f, irq);
         wreg(ZXD_IDX_STATUS, 8'h00);
         rreg("flag kept", ZXD_IDX_STATUS, {27'h0, 1'b1, 3'h0, f});
         wreg(ZXD_IDX_STATUS, 8'h01);
         chk1("irq cleared", 1'b0, irq);
         level <= 1'b0;
         repeat (12) @(posedge clk);
         rreg("fall status", ZXD_IDX_STATUS, {31'h0, m >= 2});
         wreg(ZXD_IDX_STATUS, 8'h01);
      end
      wreg(ZXD_IDX_CONTROL, 8'h09);
      repeat (8) @(posedge clk);
      rreg("inverted status", ZXD_IDX_STATUS, 32'h11);
      chk1("inverted event", 1'b1, evt);
      chk1("irq raised", 1'b1, irq);
      wreg(ZXD_IDX_IRQ_ENABLE, 8'h00);
      chk1("irq masked", 1'b0, irq);
      wreg(ZXD_IDX_IRQ_ENABLE, 8'h01);
      wreg(ZXD_IDX_IRQ_CLEAR, 8'h01);
      chk1("irq clear reg", 1'b0, irq);
      rreg("irq status", ZXD_IDX_IRQ_STATUS, 32'h2);
      rreg("cross count", ZXD_IDX_CROSS_COUNT, 32'h5);
      apb(1'b1, {ZXD_IDX_IRQ_STATUS, 2'b00}, 32'h7, r, e);
      chk1("read-only error", 1'b1, e);
      wreg(ZXD_IDX_CROSS_COUNT, 8'h00);
      rreg("count cleared", ZXD_IDX_CROSS_COUNT, 32'h0);
      wreg(ZXD_IDX_IRQ_ENABLE, 8'h02);
      chk1("toggle irq", 1'b1, irq);
      wreg(ZXD_IDX_IRQ_CLEAR, 8'h02);
      chk1("toggle cleared", 1'b0, irq);
      wreg(ZXD_IDX_IRQ_ENABLE, 8'h01);
      chk1("pin released", 1'b1, oe_n);
      wreg(ZXD_IDX_CONTROL, 8'h49);
      chk1("pin driven", 1'b0, oe_n);
      chk1("pin level", 1'b1, pin);
      sleep <= ZXD_SLEEP_IDLE;
      @(posedge clk);
      chk1("idle on", 1'b1, den);
      sleep <= ZXD_SLEEP_STANDBY;
      @(posedge clk);
      chk1("standby off", 1'b0, den);
      wreg(ZXD_IDX_CONTROL, 8'hC9);
      chk1("standby run", 1'b1, den);
      sleep <= ZXD_SLEEP_POWERDOWN;
      @(posedge clk);
      chk1("powerdown off", 1'b0, den);
      chk1("powerdown pin", 1'b1, oe_n);
      final_report();
   end
endmodule : tb_zero_cross_detect_ctrl

bind zxd_top zxd_monitor MON (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .sleep_mode_i(sleep_mode_i),
   .comp_i(comp_i), .detector_enable_o(detector_enable_o), .pin_o(pin_o),
   .pin_oe_n_o(pin_oe_n_o), .event_o(event_o), .irq_o(irq_o));
